// File: mc_datapath_pkg.sv
// constants, state codes and reset values for the motion-compensation datapath
// assumes 8-bit samples and 8x8 blocks scanned column by column
package mc_datapath_pkg;
  localparam int unsigned SAMPLE_W        = 8;
  localparam int unsigned BLK_SAMPLES     = 64;
  localparam int unsigned BLK_CNT_W       = 6;
  localparam int unsigned PAIR_CNT_W      = 7;
  localparam int unsigned LINE_LEN_DEF    = 5760;
  localparam int unsigned PRED_DEPTH_DEF  = 64;
  localparam logic [5:0]  BLK_LAST        = 6'h3f;
  localparam logic [6:0]  BLK_FULL        = 7'h40;
  localparam logic [6:0]  PAIR_LAST       = 7'h7f;
  localparam logic [6:0]  CNT7_RST        = 7'h00;
  localparam logic [5:0]  CNT6_RST        = 6'h00;
  localparam logic [7:0]  SAMPLE_RST      = 8'h00;

  typedef enum logic [2:0] {
    ST_WAIT_MV  = 3'b001,
    ST_PREDICT  = 3'b010,
    ST_AWAIT_RC = 3'b100
  } mc_state_t;
endpackage

// File: mc_far_side.sv
// far-side model: prediction sample source and coder sink of the frame datapath
// assumes handshakes are taken on the rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none
module mc_far_side
  import mc_datapath_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                slow_in,
  input  wire logic                mv_valid_in,
  input  wire logic                y_ready_in,
  input  wire logic                c_ready_in,
  output logic                     y_valid_out,
  output logic      [SAMPLE_W-1:0] y_data_out,
  output logic                     c_valid_out,
  output logic      [SAMPLE_W-1:0] c_data_out,
  output logic                     coder_ready_out
);
  int   y_idx = 64;
  int   c_idx = 64;
  int   cyc   = 0;
  logic hs_y  = 1'b0;
  logic hs_c  = 1'b0;
  logic mv_q  = 1'b0;
  initial begin
    y_valid_out     = 1'b0;
    y_data_out      = 8'h00;
    c_valid_out     = 1'b0;
    c_data_out      = 8'h00;
    coder_ready_out = 1'b0;
  end
  // sample handshakes mid-cycle so the edge that takes them is unambiguous
  always @(negedge clk_in) begin
    hs_y = y_valid_out && y_ready_in;
    hs_c = c_valid_out && c_ready_in;
    mv_q = mv_valid_in;
  end
  always @(posedge clk_in) begin
    #1;
    cyc = cyc + 1;
    // a new vector only restarts an idle source
    if (mv_q && y_idx >= 64 && c_idx >= 64) begin
      y_idx = 0;
      c_idx = 0;
    end else begin
      if (hs_y) y_idx = y_idx + 1;
      if (hs_c) c_idx = c_idx + 1;
    end
    y_valid_out = (y_idx < 64);
    c_valid_out = (c_idx < 64);
    // an idle bus toggles instead of holding the last sample
    y_data_out = y_valid_out ? {2'b01, 6'(y_idx)} : ~y_data_out;
    c_data_out = c_valid_out ? {2'b10, 6'(c_idx)} : ~c_data_out;
    // slow coder takes one of four cycles, enough to fill a short fifo
    coder_ready_out = !slow_in || (cyc % 4 == 0);
  end
endmodule
`default_nettype wire

// File: mc_frame_datapath.sv
// motion-compensation frame datapath: search window feed, prediction out, reconstruction in
// assumes the coder, decoder and frame-buffer address logic pace their streams externally
//
// How it works
// [R01] input arrives as 8x8 column-scanned blocks, one luma then one chroma
// [R02] only luma reaches the estimator, at pixel rate; chroma bypasses to coder
// [R03] lower band from frame buffer, middle from first delay, upper from second
// [R04] each of the two cascaded delay lines delays by one block line
// [R05] estimator disable held at 1 while chroma windows are copied
// [R06] luma and chroma predictions read in parallel at f, sent alternately at 2f
// [R07] reconstructed blocks alternate luma/chroma, each written to its own field
// [R08] each stored block ends with exactly one serial-to-array transfer
// [R09] a known motion vector starts prediction of both luma and chroma
// [R10] predicted block goes out, then the reconstructed block is awaited
// [R11] estimator gets one pixel on each of its four buses per beat
// [R12] fifo read withheld when empty; prediction reads stall when full
`timescale 1ns/1ps
`default_nettype none
module mc_frame_datapath
  import mc_datapath_pkg::*;
#(
  parameter int unsigned LINE_LEN   = LINE_LEN_DEF,
  parameter int unsigned PRED_DEPTH = PRED_DEPTH_DEF
) (
  input  wire logic                CLK_IN,
  input  wire logic                NRST_IN,
  input  wire logic                REF_VALID_IN,
  input  wire logic [SAMPLE_W-1:0] REF_DATA_IN,
  input  wire logic                SW_VALID_IN,
  input  wire logic [SAMPLE_W-1:0] SW_DATA_IN,
  input  wire logic                CHROMA_COPY_IN,
  input  wire logic                MV_VALID_IN,
  input  wire logic                PRED_Y_VALID_IN,
  input  wire logic [SAMPLE_W-1:0] PRED_Y_DATA_IN,
  input  wire logic                PRED_C_VALID_IN,
  input  wire logic [SAMPLE_W-1:0] PRED_C_DATA_IN,
  input  wire logic                CODER_PRED_READY_IN,
  input  wire logic                REC_VALID_IN,
  input  wire logic [SAMPLE_W-1:0] REC_DATA_IN,
  output logic                     ME_BEAT_OUT,
  output logic      [SAMPLE_W-1:0] ME_REF_OUT,
  output logic      [SAMPLE_W-1:0] ME_UPPER_OUT,
  output logic      [SAMPLE_W-1:0] ME_MIDDLE_OUT,
  output logic      [SAMPLE_W-1:0] ME_LOWER_OUT,
  output logic                     ME_DISABLE_OUT,
  output logic                     CODER_CHROMA_VALID_OUT,
  output logic      [SAMPLE_W-1:0] CODER_CHROMA_DATA_OUT,
  output logic                     PRED_Y_READY_OUT,
  output logic                     PRED_C_READY_OUT,
  output logic                     CODER_PRED_VALID_OUT,
  output logic      [SAMPLE_W-1:0] CODER_PRED_DATA_OUT,
  output logic                     CODER_PRED_IS_Y_OUT,
  output logic                     REC_READY_OUT,
  output logic                     FBY_WR_OUT,
  output logic      [SAMPLE_W-1:0] FBY_WR_DATA_OUT,
  output logic                     FBY_XFER_OUT,
  output logic                     FBC_WR_OUT,
  output logic      [SAMPLE_W-1:0] FBC_WR_DATA_OUT,
  output logic                     FBC_XFER_OUT
);
  localparam int unsigned LW = $clog2(PRED_DEPTH) + 1;

  typedef struct packed {
    mc_state_t                 st;
    logic                      phase;
    logic [BLK_CNT_W-1:0]      ref_cnt;
    logic                      ref_is_c;
    logic [SAMPLE_W-1:0]       ref_y;
    logic                      beat;
    logic [SAMPLE_W-1:0]       me_ref;
    logic [SAMPLE_W-1:0]       me_up;
    logic [SAMPLE_W-1:0]       me_mid;
    logic [SAMPLE_W-1:0]       me_low;
    logic                      me_dis;
    logic                      cb_val;
    logic [SAMPLE_W-1:0]       cb_data;
    logic [PAIR_CNT_W-1:0]     ycnt;
    logic [PAIR_CNT_W-1:0]     ccnt;
    logic                      rdy_y;
    logic                      rdy_c;
    logic                      out_val;
    logic [SAMPLE_W-1:0]       out_data;
    logic                      out_is_y;
    logic                      sel_c;
    logic [BLK_CNT_W-1:0]      sel_cnt;
    logic [PAIR_CNT_W-1:0]     dcnt;
    logic [PAIR_CNT_W-1:0]     rcnt;
    logic                      rec_rdy;
    logic                      fy_wr;
    logic                      fc_wr;
    logic [SAMPLE_W-1:0]       fb_data;
    logic                      fy_xfer;
    logic                      fc_xfer;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic [SAMPLE_W-1:0] mid_band;
  logic [SAMPLE_W-1:0] up_band;
  logic                fy_in_rdy;
  logic                fc_in_rdy;
  logic                fy_out_val;
  logic                fc_out_val;
  logic [SAMPLE_W-1:0] fy_out_data;
  logic [SAMPLE_W-1:0] fc_out_data;
  logic [LW-1:0]       fy_lvl;
  logic [LW-1:0]       fc_lvl;
  logic                y_push;
  logic                c_push;
  logic                y_pop;
  logic                c_pop;
  logic                out_take;
  logic                stage_free;

  // lower band feeds the first line, its output feeds the second
  mc_line_delay #(.LEN(LINE_LEN), .W(SAMPLE_W)) u_dl_mid (
    .clk_in   (CLK_IN),
    .nrst_in  (NRST_IN),
    .shift_in (SW_VALID_IN),
    .data_in  (SW_DATA_IN),
    .data_out (mid_band)
  );
  mc_line_delay #(.LEN(LINE_LEN), .W(SAMPLE_W)) u_dl_up (
    .clk_in   (CLK_IN),
    .nrst_in  (NRST_IN),
    .shift_in (SW_VALID_IN),
    .data_in  (mid_band),
    .data_out (up_band)
  );

  assign y_push = s_q.rdy_y && PRED_Y_VALID_IN;
  assign c_push = s_q.rdy_c && PRED_C_VALID_IN;

  mc_sync_fifo #(.WIDTH(SAMPLE_W), .DEPTH(PRED_DEPTH)) u_fifo_y (
    .clk_in        (CLK_IN),
    .nrst_in       (NRST_IN),
    .in_valid_in   (y_push),
    .in_data_in    (PRED_Y_DATA_IN),
    .in_ready_out  (fy_in_rdy),
    .out_valid_out (fy_out_val),
    .out_data_out  (fy_out_data),
    .out_ready_in  (y_pop),
    .level_out     (fy_lvl)
  );
  mc_sync_fifo #(.WIDTH(SAMPLE_W), .DEPTH(PRED_DEPTH)) u_fifo_c (
    .clk_in        (CLK_IN),
    .nrst_in       (NRST_IN),
    .in_valid_in   (c_push),
    .in_data_in    (PRED_C_DATA_IN),
    .in_ready_out  (fc_in_rdy),
    .out_valid_out (fc_out_val),
    .out_data_out  (fc_out_data),
    .out_ready_in  (c_pop),
    .level_out     (fc_lvl)
  );

  assign out_take   = s_q.out_val && CODER_PRED_READY_IN;
  assign stage_free = !s_q.out_val || out_take;
  assign y_pop      = stage_free && !s_q.sel_c && fy_out_val; // [R12]
  assign c_pop      = stage_free && s_q.sel_c && fc_out_val; // [R12]

  function automatic logic room(input logic [LW-1:0] lvl, input logic push);
    room = ({1'b0, lvl} + (LW+1)'(push)) < (LW+1)'(PRED_DEPTH);
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.phase   = ~s_q.phase;
    s_d.cb_val  = 1'b0;
    s_d.beat    = 1'b0;
    s_d.fy_wr   = 1'b0;
    s_d.fc_wr   = 1'b0;
    s_d.fy_xfer = 1'b0;
    s_d.fc_xfer = 1'b0;
    // reference stream: block count decides luma or chroma
    if (REF_VALID_IN) begin
      s_d.ref_cnt = s_q.ref_cnt + 1'b1; // [R01]
      if (s_q.ref_cnt == BLK_LAST) begin
        s_d.ref_is_c = ~s_q.ref_is_c; // [R01]
      end
      if (s_q.ref_is_c) begin
        s_d.cb_val  = 1'b1; // [R02]
        s_d.cb_data = REF_DATA_IN; // [R02]
      end else begin
        s_d.ref_y = REF_DATA_IN; // [R02]
      end
    end
    // all four buses change together, one beat per frame-buffer sample
    s_d.me_dis = CHROMA_COPY_IN; // [R05]
    if (SW_VALID_IN) begin
      s_d.beat   = 1'b1; // [R11]
      s_d.me_ref = s_q.ref_y; // [R02]
      s_d.me_low = SW_DATA_IN; // [R03]
      s_d.me_mid = mid_band; // [R03]
      s_d.me_up  = up_band; // [R03]
    end
    // prediction side
    if (y_push) begin
      s_d.ycnt = s_q.ycnt + 1'b1;
    end
    if (c_push) begin
      s_d.ccnt = s_q.ccnt + 1'b1;
    end
    if (out_take) begin
      s_d.out_val = 1'b0;
      s_d.dcnt    = s_q.dcnt + 1'b1;
    end
    if (y_pop || c_pop) begin
      s_d.out_val  = 1'b1;
      s_d.out_data = y_pop ? fy_out_data : fc_out_data;
      s_d.out_is_y = y_pop; // [R06]
      s_d.sel_cnt  = s_q.sel_cnt + 1'b1;
      if (s_q.sel_cnt == BLK_LAST) begin
        s_d.sel_c = ~s_q.sel_c; // [R06]
      end
    end
    // reconstruction: 64 luma then 64 chroma, one transfer per block
    if (s_q.rec_rdy && REC_VALID_IN) begin
      s_d.rcnt    = s_q.rcnt + 1'b1;
      s_d.fb_data = REC_DATA_IN; // [R07]
      s_d.fy_wr   = !s_q.rcnt[BLK_CNT_W]; // [R07]
      s_d.fc_wr   = s_q.rcnt[BLK_CNT_W]; // [R07]
      if (s_q.rcnt[BLK_CNT_W-1:0] == BLK_LAST) begin
        s_d.fy_xfer = !s_q.rcnt[BLK_CNT_W]; // [R08]
        s_d.fc_xfer = s_q.rcnt[BLK_CNT_W]; // [R08]
      end
    end
    unique case (s_q.st)
      ST_WAIT_MV: begin
        if (MV_VALID_IN) begin
          s_d.st   = ST_PREDICT; // [R09]
          s_d.ycnt = CNT7_RST;
          s_d.ccnt = CNT7_RST;
          s_d.dcnt = CNT7_RST;
        end
      end
      ST_PREDICT: begin
        if (out_take && s_q.dcnt == PAIR_LAST) begin
          s_d.st   = ST_AWAIT_RC; // [R10]
          s_d.rcnt = CNT7_RST;
        end
      end
      ST_AWAIT_RC: begin
        if (s_q.rec_rdy && REC_VALID_IN && s_q.rcnt == PAIR_LAST) begin
          s_d.st = ST_WAIT_MV; // [R10]
        end
      end
    endcase
    // reads run in parallel at half the clock, and only while the fifo has room
    s_d.rdy_y = (s_d.st == ST_PREDICT) && s_d.phase && (s_d.ycnt < BLK_FULL)
                && room(fy_lvl, y_push) && fy_in_rdy; // [R06] [R12]
    s_d.rdy_c = (s_d.st == ST_PREDICT) && s_d.phase && (s_d.ccnt < BLK_FULL)
                && room(fc_lvl, c_push) && fc_in_rdy; // [R06] [R12]
    s_d.rec_rdy = (s_d.st == ST_AWAIT_RC); // [R10]
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s_q          <= '0;
      s_q.st       <= ST_WAIT_MV;
      s_q.ref_cnt  <= CNT6_RST;
      s_q.sel_cnt  <= CNT6_RST;
      s_q.ref_y    <= SAMPLE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ME_BEAT_OUT            = s_q.beat;
  assign ME_REF_OUT             = s_q.me_ref;
  assign ME_UPPER_OUT           = s_q.me_up;
  assign ME_MIDDLE_OUT          = s_q.me_mid;
  assign ME_LOWER_OUT           = s_q.me_low;
  assign ME_DISABLE_OUT         = s_q.me_dis;
  assign CODER_CHROMA_VALID_OUT = s_q.cb_val;
  assign CODER_CHROMA_DATA_OUT  = s_q.cb_data;
  assign PRED_Y_READY_OUT       = s_q.rdy_y;
  assign PRED_C_READY_OUT       = s_q.rdy_c;
  assign CODER_PRED_VALID_OUT   = s_q.out_val;
  assign CODER_PRED_DATA_OUT    = s_q.out_data;
  assign CODER_PRED_IS_Y_OUT    = s_q.out_is_y;
  assign REC_READY_OUT          = s_q.rec_rdy;
  assign FBY_WR_OUT             = s_q.fy_wr;
  assign FBC_WR_OUT             = s_q.fc_wr;
  assign FBY_WR_DATA_OUT        = s_q.fb_data;
  assign FBC_WR_DATA_OUT        = s_q.fb_data;
  assign FBY_XFER_OUT           = s_q.fy_xfer;
  assign FBC_XFER_OUT           = s_q.fc_xfer;

  sequence sw_sample;
    SW_VALID_IN;
  endsequence
  sequence beat_with_lower;
    ME_BEAT_OUT && ME_LOWER_OUT == $past(SW_DATA_IN);
  endsequence

  AST_LOWER_BAND: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R03]
    sw_sample |=> beat_with_lower)
    else $error("lower band not taken from frame buffer sample");
  AST_MIDDLE_BAND: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R11]
    SW_VALID_IN |=> ME_BEAT_OUT && ME_MIDDLE_OUT === $past(mid_band))
    else $error("middle band not presented with the beat");
  AST_DISABLE: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R05]
    CHROMA_COPY_IN |=> ME_DISABLE_OUT)
    else $error("estimator not disabled during chroma copy");
  AST_CHROMA_BYPASS: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R02]
    REF_VALID_IN && s_q.ref_is_c |=> CODER_CHROMA_VALID_OUT && s_q.ref_y == $past(s_q.ref_y))
    else $error("chroma sample not bypassed to coder");
  AST_READ_RATE: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R06]
    PRED_Y_READY_OUT |=> !PRED_Y_READY_OUT)
    else $error("prediction read faster than half clock");
  AST_MV_START: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R09]
    s_q.st == ST_WAIT_MV && MV_VALID_IN |=> s_q.st == ST_PREDICT)
    else $error("motion vector did not start prediction");
  AST_NO_REC_EARLY: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R10]
    s_q.st == ST_PREDICT |-> !REC_READY_OUT)
    else $error("reconstruction accepted before prediction finished");
  AST_ONE_XFER: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R08]
    FBY_XFER_OUT |=> !FBY_XFER_OUT [*2])
    else $error("more than one transfer for a luma block");
  AST_REC_FIELD: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R07]
    REC_READY_OUT && REC_VALID_IN && !s_q.rcnt[BLK_CNT_W] |=> FBY_WR_OUT && !FBC_WR_OUT)
    else $error("luma reconstruction written to wrong field");
  AST_ALTERNATE: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R06]
    CODER_PRED_VALID_OUT |-> CODER_PRED_IS_Y_OUT == !s_q.dcnt[BLK_CNT_W])
    else $error("predicted block order is not luma then chroma");
endmodule
`default_nettype wire

// File: mc_frame_datapath_tb.sv
// self-checking bench for the frame datapath, far side modelled by mc_far_side
// assumes a 25 MHz clock, a short delay line and a 4-word prediction fifo
`timescale 1ns/1ps
`default_nettype none
module mc_frame_datapath_tb
  import mc_datapath_pkg::*;
;
  localparam int unsigned LLEN = 8;
  logic       clk = 1'b0, nrst, slow, rv, sv, cc, mv, pyv, pcv, cr, recv;
  logic [7:0] rd, sd, pyd, pcd, recd;
  logic       beat, dis, chv, pyr, pcr, pv, isy, recr, yw, yx, cw, cx;
  logic [7:0] mref, mup, mmid, mlow, chd, pd, yd, cd;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  mc_frame_datapath #(.LINE_LEN(LLEN), .PRED_DEPTH(4)) u_dut (
    .CLK_IN(clk), .NRST_IN(nrst), .REF_VALID_IN(rv), .REF_DATA_IN(rd),
    .SW_VALID_IN(sv), .SW_DATA_IN(sd), .CHROMA_COPY_IN(cc), .MV_VALID_IN(mv),
    .PRED_Y_VALID_IN(pyv), .PRED_Y_DATA_IN(pyd), .PRED_C_VALID_IN(pcv),
    .PRED_C_DATA_IN(pcd), .CODER_PRED_READY_IN(cr), .REC_VALID_IN(recv),
    .REC_DATA_IN(recd), .ME_BEAT_OUT(beat), .ME_REF_OUT(mref), .ME_UPPER_OUT(mup),
    .ME_MIDDLE_OUT(mmid), .ME_LOWER_OUT(mlow), .ME_DISABLE_OUT(dis),
    .CODER_CHROMA_VALID_OUT(chv), .CODER_CHROMA_DATA_OUT(chd),
    .PRED_Y_READY_OUT(pyr), .PRED_C_READY_OUT(pcr), .CODER_PRED_VALID_OUT(pv),
    .CODER_PRED_DATA_OUT(pd), .CODER_PRED_IS_Y_OUT(isy), .REC_READY_OUT(recr),
    .FBY_WR_OUT(yw), .FBY_WR_DATA_OUT(yd), .FBY_XFER_OUT(yx),
    .FBC_WR_OUT(cw), .FBC_WR_DATA_OUT(cd), .FBC_XFER_OUT(cx));

  mc_far_side u_far (
    .clk_in(clk), .slow_in(slow), .mv_valid_in(mv), .y_ready_in(pyr),
    .c_ready_in(pcr), .y_valid_out(pyv), .y_data_out(pyd), .c_valid_out(pcv),
    .c_data_out(pcd), .coder_ready_out(cr));

  always #20 clk = ~clk;

  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ceiling well above the roughly 830 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // 64 luma then 64 chroma samples back to back; only chroma reaches the coder
  task automatic t_ref();
    logic [7:0] v;
    for (int i = 0; i < 128; i++) begin
      v = 8'(i) ^ 8'h5a;
      rv = 1'b1;
      rd = v;
      tick();
      chk1(chv, i >= 64);
      if (i >= 64) check(chd, v);
    end
    rv = 1'b0;
    tick();
    chk1(chv, 1'b0);
  endtask

  // back-to-back beats; bands must be the stream and its two line-delayed copies
  task automatic t_sw();
    logic [7:0] v;
    for (int k = 0; k < 24; k++) begin
      v = 8'h10 + 8'(k);
      sv = 1'b1;
      sd = v;
      tick();
      chk1(beat, 1'b1);
      check(mlow, v);
      check(mref, 8'h3f ^ 8'h5a);
      if (k >= 16) begin
        check(mmid, v - 8'(LLEN));
        check(mup, v - 8'(2 * LLEN));
      end
    end
    sv = 1'b0;
    tick();
    chk1(beat, 1'b0);
    check(mlow, 8'h27);
  endtask

  task automatic t_disable();
    cc = 1'b1;
    repeat (3) begin
      tick();
      chk1(dis, 1'b1);
    end
    cc = 1'b0;
    tick();
    chk1(dis, 1'b0);
  endtask

  // slow coder fills the fifo; a second vector mid-block must be ignored
  task automatic t_predict();
    int         n;
    int         guard;
    logic [7:0] e;
    slow = 1'b1;
    mv = 1'b1;
    tick();
    mv = 1'b0;
    chk1(recr, 1'b0);
    repeat (3) tick();
    mv = 1'b1;
    tick();
    mv = 1'b0;
    n = 0;
    guard = 0;
    while (n < 128 && guard < 3000) begin
      @(negedge clk);
      guard++;
      if (pv && cr) begin
        e = (n < 64) ? {2'b01, 6'(n)} : {2'b10, 6'(n)};
        chk1(isy, n < 64);
        check(pd, e);
        n++;
      end
    end
    check(8'(n), 8'd128);
    slow = 1'b0;
    repeat (4) tick();
    chk1(recr, 1'b1);
    chk1(pv, 1'b0);
    chk1(pyr | pcr, 1'b0);
  endtask

  // luma block then chroma block, one row transfer each, then refusal when idle
  task automatic t_rec();
    logic [7:0] v;
    for (int j = 0; j < 128; j++) begin
      v = 8'(j) ^ 8'ha5;
      recv = 1'b1;
      recd = v;
      tick();
      chk1(yw, j < 64);
      chk1(cw, j >= 64);
      check((j < 64) ? yd : cd, v);
      chk1(yx, j == 63);
      chk1(cx, j == 127);
    end
    recv = 1'b0;
    repeat (3) tick();
    chk1(recr, 1'b0);
    recv = 1'b1;
    recd = 8'h11;
    repeat (2) tick();
    chk1(yw | cw, 1'b0);
    recv = 1'b0;
  endtask

  initial begin
    {nrst, slow, rv, sv, cc, mv, recv} = 7'h00;
    {rd, sd, recd} = 24'h000000;
    repeat (8) tick();
    check({beat, dis, chv, pv, recr, yw, cw, yx}, 8'h00);
    nrst = 1'b1;
    tick();
    t_ref();
    t_sw();
    t_disable();
    t_predict();
    t_rec();
    final_report();
  end
endmodule
`default_nettype wire

// File: mc_line_delay.sv
// one-block-line delay for a search-window band, single-port ram with a down counter
// assumes shift pulses arrive at most once per clock; read happens before write
`timescale 1ns/1ps
`default_nettype none
module mc_line_delay
  import mc_datapath_pkg::*;
#(
  parameter int unsigned LEN = LINE_LEN_DEF,
  parameter int unsigned W   = SAMPLE_W
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         shift_in,
  input  wire logic [W-1:0] data_in,
  output logic      [W-1:0] data_out
);
  localparam int unsigned PW = $clog2(LEN);
  localparam logic [PW-1:0] PTR_TOP = PW'(LEN - 1);

  typedef struct packed {
    logic [PW-1:0] ptr;
  } dl_state_t;

  dl_state_t s_q;
  dl_state_t s_d;
  logic [W-1:0] mem [LEN];

  // old value comes out combinationally so the band lines up with the live sample
  assign data_out = mem[s_q.ptr];

  always_comb begin
    s_d = s_q;
    if (shift_in) begin
      s_d.ptr = (s_q.ptr == '0) ? PTR_TOP : s_q.ptr - 1'b1; // [R04]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q.ptr <= PTR_TOP;
    end else begin
      s_q <= s_d;
    end
  end

  // ram content is not reset; the first line out is stale by nature
  always_ff @(posedge clk_in) begin
    if (shift_in) begin
      mem[s_q.ptr] <= data_in;
    end
  end
endmodule
`default_nettype wire

// File: mc_sync_fifo.sv
// synchronous fifo with valid/ready on both sides, used for rate adaptation
// assumes one clock; full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module mc_sync_fifo
  import mc_datapath_pkg::*;
#(
  parameter int unsigned WIDTH = SAMPLE_W,
  parameter int unsigned DEPTH = PRED_DEPTH_DEF
) (
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  input  wire logic               in_valid_in,
  input  wire logic [WIDTH-1:0]   in_data_in,
  output logic                    in_ready_out,
  output logic                    out_valid_out,
  output logic      [WIDTH-1:0]   out_data_out,
  input  wire logic               out_ready_in,
  output logic      [$clog2(DEPTH):0] level_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   lvl;
  } ff_state_t;

  ff_state_t s_q;
  ff_state_t s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out  = (s_q.lvl != (AW+1)'(DEPTH));
  assign out_valid_out = (s_q.lvl != '0); // [R12]
  assign out_data_out  = mem[s_q.rp];
  assign level_out     = s_q.lvl;
  assign push          = in_valid_in && in_ready_out; // [R12]
  assign pop           = out_valid_out && out_ready_in;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
    wrap = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = wrap(s_q.wp);
    end
    if (pop) begin
      s_d.rp = wrap(s_q.rp);
    end
    s_d.lvl = s_q.lvl + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[s_q.wp] <= in_data_in;
    end
  end

  // the feeder must look ahead; a word offered to a full fifo would be lost
  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R12]
    in_valid_in |-> in_ready_out)
    else $error("word offered to a full fifo");
  AST_FIFO_LEVEL_TRACK: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R12]
    push && !pop |=> s_q.lvl == $past(s_q.lvl) + 1'b1)
    else $error("fifo level did not grow on a lone push");
endmodule
`default_nettype wire
